//--- verilog/uart_pkg.sv
/*
 * Shared constants and types for the serial port block: register offsets,
 * field positions, reset values, FIFO depths and the block's state record.
 * Assumes a single 250 MHz clock domain and an AHB-Lite register bus.
 */
`default_nettype none
package uart_pkg;
    // Register byte offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] TXDATA_OFS = 8'h08;
    localparam logic [7:0] RXDATA_OFS = 8'h0C;
    localparam logic [7:0] IFLAG_OFS = 8'h10;
    localparam logic [7:0] BAUD_OFS = 8'h14;
    // Status field positions
    localparam int RXAVAIL_BIT = 0;
    localparam int OVERRUN_BIT = 1;
    localparam int FRAMING_ERR_BIT = 2;
    localparam int PARITY_ERR_BIT = 3;
    localparam int RXSEL_LSB = 6;
    localparam int TXFULL_BIT = 8;
    localparam int TXIDLE_BIT = 9;
    localparam int BREAK_BIT = 11;
    localparam int TXSEL_BIT = 15;
    // Control and flag field positions
    localparam int ENABLE_BIT = 0;
    localparam int PAREN_BIT = 1;
    localparam int TXFLAG_BIT = 0;
    localparam int RXFLAG_BIT = 1;
    // Reset values and sizes
    localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
    localparam int TX_DEPTH = 4;
    localparam int RX_DEPTH = 4;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_e;

    typedef struct packed {
        logic [TX_DEPTH-1:0][7:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [2:0] count;
    } tx_fifo_s;

    typedef struct packed {
        logic [RX_DEPTH-1:0][9:0] mem;
        logic [1:0] rd;
        logic [1:0] wr;
        logic [2:0] count;
    } rx_fifo_s;

    typedef struct packed {
        // Bus side
        logic dphValid;
        logic dphWrite;
        logic [7:0] dphAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        // Software settings and flags
        logic enable;
        logic parityEn;
        logic txBreakCtl;
        logic txIrqSelect;
        logic [1:0] rxIrqSelect;
        logic overrunErr;
        logic txIrqFlag;
        logic rxIrqFlag;
        logic [15:0] baudDiv;
        logic [15:0] baudCnt;
        // Transmit path
        tx_fifo_s txBuf;
        logic [10:0] txShift;
        logic [3:0] txBitsLeft;
        logic [3:0] txSub;
        logic serialTxLine;
        // Receive path
        rx_fifo_s rxBuf;
        rx_state_e rxState;
        logic [8:0] rxShift;
        logic [3:0] rxSub;
        logic [3:0] rxBitIdx;
        logic [9:0] rxLastRead;
    } uart_state_s;
endpackage
`default_nettype wire

//--- verilog/uart_tx_rx_interrupt_fifo.sv
/*
 * Serial port with transmit buffer, break control, four-word receive FIFO,
 * threshold-based receive interrupt flags and overrun detection, reached
 * over AHB-Lite. Assumes inputs synchronous to clk and a single slave bus.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_tx_rx_interrupt_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial lines
    input wire logic serialRxLine,
    output logic serialTxLine,
    // Interrupt flags for the interrupt controller
    output logic txIrqFlag,
    output logic rxIrqFlag
);
    import uart_pkg::*;

    uart_state_s s_r;
    uart_state_s s_nxt;
    logic hrespZero_r;

    logic baudTick;
    logic addrPhase;
    logic wrStatus;
    logic wrCtrl;
    logic wrTx;
    logic wrFlag;
    logic wrBaud;
    logic rxPop;
    logic txPush;
    logic txMove;
    logic txEvent;
    logic rxDone;
    logic rxPush;
    logic rxEvent;
    logic overrunSet;
    logic [7:0] txWord;
    logic [7:0] rxWord;
    logic [9:0] rxHead;
    logic [2:0] rxCountAfter;
    logic [3:0] rxBitsTotal;

    assign hrdata = s_r.hrdata;
    assign hreadyout = s_r.hreadyout;
    assign hresp = hrespZero_r;
    assign serialTxLine = s_r.serialTxLine;
    assign txIrqFlag = s_r.txIrqFlag;
    assign rxIrqFlag = s_r.rxIrqFlag;

    always_comb begin
        s_nxt = s_r;
        // Bus decode; zero wait states, so hready is always high here
        addrPhase = hsel && htrans[1] && hready;
        wrStatus = s_r.dphValid && s_r.dphWrite && (s_r.dphAddr == STATUS_OFS);
        wrCtrl = s_r.dphValid && s_r.dphWrite && (s_r.dphAddr == CTRL_OFS);
        wrTx = s_r.dphValid && s_r.dphWrite && (s_r.dphAddr == TXDATA_OFS);
        wrFlag = s_r.dphValid && s_r.dphWrite && (s_r.dphAddr == IFLAG_OFS);
        wrBaud = s_r.dphValid && s_r.dphWrite && (s_r.dphAddr == BAUD_OFS);
        rxHead = s_r.rxBuf.mem[s_r.rxBuf.rd];
        // Empty buffer: no pop, previous word stays readable
        rxPop = addrPhase && !hwrite && (haddr[7:0] == RXDATA_OFS)
            && (s_r.rxBuf.count != 3'd0);
        s_nxt.dphValid = addrPhase;
        s_nxt.dphWrite = hwrite;
        s_nxt.dphAddr = haddr[7:0];
        s_nxt.hreadyout = 1'b1;

        // Read data is prepared in the address phase so it leaves a flop
        if (addrPhase && !hwrite) begin
            s_nxt.hrdata = 32'h0000_0000;
            if (haddr[7:0] == STATUS_OFS) begin
                s_nxt.hrdata[RXAVAIL_BIT] = (s_r.rxBuf.count != 3'd0);
                s_nxt.hrdata[OVERRUN_BIT] = s_r.overrunErr;
                s_nxt.hrdata[FRAMING_ERR_BIT] = (s_r.rxBuf.count != 3'd0) ? rxHead[8] : 1'b0;
                s_nxt.hrdata[PARITY_ERR_BIT] = (s_r.rxBuf.count != 3'd0) ? rxHead[9] : 1'b0;
                s_nxt.hrdata[RXSEL_LSB +: 2] = s_r.rxIrqSelect;
                s_nxt.hrdata[TXFULL_BIT] = (s_r.txBuf.count == 3'(TX_DEPTH));
                s_nxt.hrdata[TXIDLE_BIT] = (s_r.txBitsLeft == 4'd0) && (s_r.txBuf.count == 3'd0);
                s_nxt.hrdata[BREAK_BIT] = s_r.txBreakCtl;
                s_nxt.hrdata[TXSEL_BIT] = s_r.txIrqSelect;
            end else if (haddr[7:0] == CTRL_OFS) begin
                s_nxt.hrdata[ENABLE_BIT] = s_r.enable;
                s_nxt.hrdata[PAREN_BIT] = s_r.parityEn;
            end else if (haddr[7:0] == RXDATA_OFS) begin
                s_nxt.hrdata[7:0] = rxPop ? rxHead[7:0] : s_r.rxLastRead[7:0];
            end else if (haddr[7:0] == IFLAG_OFS) begin
                s_nxt.hrdata[TXFLAG_BIT] = s_r.txIrqFlag;
                s_nxt.hrdata[RXFLAG_BIT] = s_r.rxIrqFlag;
            end else if (haddr[7:0] == BAUD_OFS) begin
                s_nxt.hrdata[15:0] = s_r.baudDiv;
            end
        end
        if (rxPop) begin
            s_nxt.rxLastRead = rxHead;
        end

        // Register writes in the data phase
        if (wrStatus) begin
            s_nxt.rxIrqSelect = hwdata[RXSEL_LSB +: 2];
            s_nxt.txBreakCtl = hwdata[BREAK_BIT];
            s_nxt.txIrqSelect = hwdata[TXSEL_BIT];
        end
        if (wrCtrl) begin
            s_nxt.enable = hwdata[ENABLE_BIT];
            s_nxt.parityEn = hwdata[PAREN_BIT];
        end
        if (wrBaud) begin
            s_nxt.baudDiv = hwdata[15:0];
        end

        // Oversampling tick at sixteen times the bit rate
        baudTick = (s_r.baudCnt == s_r.baudDiv);
        s_nxt.baudCnt = baudTick ? 16'h0000 : s_r.baudCnt + 16'h0001;

        // Transmit buffer fill; a write to a full buffer is dropped
        txPush = wrTx && (s_r.txBuf.count != 3'(TX_DEPTH));
        txWord = hwdata[7:0];
        // No moves during break, so a break cannot raise the flag
        txMove = s_r.enable && !s_r.txBreakCtl && (s_r.txBitsLeft == 4'd0)
            && (s_r.txBuf.count != 3'd0);
        // Select read live, so a change affects only later moves
        txEvent = txMove && (!s_r.txIrqSelect || (s_r.txBuf.count == 3'd1 && !txPush));
        if (txPush) begin
            s_nxt.txBuf.mem[s_r.txBuf.wr] = txWord;
            s_nxt.txBuf.wr = s_r.txBuf.wr + 2'd1;
        end
        if (txMove) begin
            s_nxt.txBuf.rd = s_r.txBuf.rd + 2'd1;
            s_nxt.txBitsLeft = s_r.parityEn ? 4'd11 : 4'd10;
            s_nxt.txSub = 4'h0;
            s_nxt.txShift = s_r.parityEn
                ? {1'b1, ^s_r.txBuf.mem[s_r.txBuf.rd], s_r.txBuf.mem[s_r.txBuf.rd], 1'b0}
                : {1'b1, 1'b1, s_r.txBuf.mem[s_r.txBuf.rd], 1'b0};
        end else if (s_r.txBitsLeft != 4'd0 && baudTick) begin
            s_nxt.txSub = s_r.txSub + 4'h1;
            if (s_r.txSub == OVS_LAST) begin
                s_nxt.txShift = {1'b1, s_r.txShift[10:1]};
                s_nxt.txBitsLeft = s_r.txBitsLeft - 4'd1;
            end
        end
        s_nxt.txBuf.count = s_r.txBuf.count + 3'(txPush) - 3'(txMove);
        // Break holds the line low over any frame in flight
        if (s_r.txBreakCtl) begin
            s_nxt.serialTxLine = 1'b0;
        end else begin
            s_nxt.serialTxLine = (s_nxt.txBitsLeft != 4'd0) ? s_nxt.txShift[0] : 1'b1;
        end

        // Receiver: mid-bit sampling off the oversampling tick
        rxDone = 1'b0;
        rxBitsTotal = s_r.parityEn ? 4'd9 : 4'd8;
        case (s_r.rxState)
            RX_IDLE: begin
                if (s_r.enable && !serialRxLine) begin
                    s_nxt.rxState = RX_START;
                    s_nxt.rxSub = 4'h0;
                end
            end
            RX_START: begin
                if (baudTick) begin
                    s_nxt.rxSub = s_r.rxSub + 4'h1;
                    if (s_r.rxSub == OVS_MID) begin
                        // A glitch shorter than half a bit is not a start
                        s_nxt.rxState = serialRxLine ? RX_IDLE : RX_DATA;
                        s_nxt.rxSub = 4'h0;
                        s_nxt.rxBitIdx = 4'd0;
                    end
                end
            end
            RX_DATA: begin
                if (baudTick) begin
                    s_nxt.rxSub = s_r.rxSub + 4'h1;
                    if (s_r.rxSub == OVS_LAST) begin
                        s_nxt.rxShift = {serialRxLine, s_r.rxShift[8:1]};
                        s_nxt.rxBitIdx = s_r.rxBitIdx + 4'd1;
                        if (s_r.rxBitIdx == rxBitsTotal - 4'd1) begin
                            s_nxt.rxState = RX_STOP;
                        end
                    end
                end
            end
            RX_STOP: begin
                if (baudTick) begin
                    s_nxt.rxSub = s_r.rxSub + 4'h1;
                    if (s_r.rxSub == OVS_LAST) begin
                        rxDone = 1'b1;
                        s_nxt.rxState = RX_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.rxState = RX_IDLE;
            end
        endcase
        rxWord = s_r.parityEn ? s_r.rxShift[7:0] : s_r.rxShift[8:1];
        // Stop bit seen: move into the buffer, or overrun if it is full and not read in the same cycle
        overrunSet = rxDone && (s_r.rxBuf.count == 3'(RX_DEPTH)) && !rxPop;
        rxPush = rxDone && !overrunSet;
        if (rxPush) begin
            s_nxt.rxBuf.mem[s_r.rxBuf.wr] = {s_r.parityEn && (^s_r.rxShift), !serialRxLine, rxWord};
            s_nxt.rxBuf.wr = s_r.rxBuf.wr + 2'd1;
        end
        if (rxPop) begin
            s_nxt.rxBuf.rd = s_r.rxBuf.rd + 2'd1;
        end
        s_nxt.rxBuf.count = s_r.rxBuf.count + 3'(rxPush) - 3'(rxPop);
        rxCountAfter = s_r.rxBuf.count - 3'(rxPop) + 3'd1;
        rxEvent = rxPush && (!s_r.rxIrqSelect[1]
            || (s_r.rxIrqSelect == 2'b10 && rxCountAfter == 3'd3)
            || (s_r.rxIrqSelect == 2'b11 && rxCountAfter == 3'd4));

        // Overrun: write 0 clears, hardware set wins over the clear
        s_nxt.overrunErr = (wrStatus ? (s_r.overrunErr & hwdata[OVERRUN_BIT]) : s_r.overrunErr)
            | overrunSet;
        // Flags: write 1 clears, a same-cycle event still sets
        s_nxt.txIrqFlag = (wrFlag ? (s_r.txIrqFlag & ~hwdata[TXFLAG_BIT]) : s_r.txIrqFlag)
            | txEvent;
        s_nxt.rxIrqFlag = (wrFlag ? (s_r.rxIrqFlag & ~hwdata[RXFLAG_BIT]) : s_r.rxIrqFlag)
            | rxEvent;
    end

    // Only a reset clears the FIFOs; there is no other clear path
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.rxState <= RX_IDLE;
            s_r.serialTxLine <= 1'b1;
            s_r.hreadyout <= 1'b1;
            s_r.baudDiv <= BAUD_DIV_RST;
            hrespZero_r <= 1'b0;
        end else begin
            s_r <= s_nxt;
            hrespZero_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- verification/uart_peer.sv
/*
 * Far-side serial device: sends frames on the receive line and decodes
 * frames seen on the transmit line. Assumes BIT clocks per bit.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_peer #(parameter int BIT = 16) (
    // Clock
    input wire logic clk,
    // Serial lines
    output logic rxLine,
    input wire logic txLine
);
    logic [7:0] got;
    logic [7:0] sh;
    initial begin
        rxLine = 1'b1;
        got = 8'h00;
    end
    // Line rests at mark level once the stop bit is out
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxLine <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask
    // Samples mid-bit; a break reads as a zero byte
    initial forever begin
        @(negedge txLine);
        repeat (BIT + BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            sh[i] = txLine;
            repeat (BIT) @(posedge clk);
        end
        got = sh;
    end
endmodule
`default_nettype wire

//--- verification/uart_tx_rx_interrupt_fifo_assertions.sv
/*
 * Checker for the serial port: flags, break and line idle behaviour.
 * Assumes it sees only the top module ports, one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_tx_rx_interrupt_fifo_checker
    import uart_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Serial lines and flags
    input wire logic serialRxLine,
    input wire logic serialTxLine,
    input wire logic txIrqFlag,
    input wire logic rxIrqFlag
);
    logic dphWr_r;
    logic brk_r;
    logic txSeen_r;
    logic brkSeen_r;
    logic [7:0] dphAddr_r;
    logic clrTx;
    logic clrRx;
    assign clrTx = dphWr_r && dphAddr_r == IFLAG_OFS && hwdata[TXFLAG_BIT];
    assign clrRx = dphWr_r && dphAddr_r == IFLAG_OFS && hwdata[RXFLAG_BIT];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dphWr_r <= 1'b0;
            dphAddr_r <= 8'h00;
            brk_r <= 1'b0;
            txSeen_r <= 1'b0;
            brkSeen_r <= 1'b0;
        end else begin
            dphWr_r <= hsel && htrans[1] && hready && hwrite;
            dphAddr_r <= haddr[7:0];
            if (dphWr_r && dphAddr_r == STATUS_OFS) begin
                brk_r <= hwdata[BREAK_BIT];
                brkSeen_r <= brkSeen_r || hwdata[BREAK_BIT];
            end
            if (dphWr_r && dphAddr_r == TXDATA_OFS) begin
                txSeen_r <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Two cycles of slack for the registered line output
    sequence brkHeld;
        brk_r && $past(brk_r) && $past(brk_r, 2);
    endsequence
    sequence startBit;
        ##[0:2] !serialTxLine;
    endsequence
    reset_idle_a: assert property ($rose(nrst) |-> serialTxLine && !txIrqFlag && !rxIrqFlag)
        else $error("outputs not idle after reset");
    break_low_a: assert property (brkHeld |-> !serialTxLine)
        else $error("transmit line high during break");
    break_noirq_a: assert property (brkHeld |-> !$rose(txIrqFlag))
        else $error("transmit flag set during break");
    tx_flag_start_a: assert property ($rose(txIrqFlag) |-> startBit)
        else $error("transmit flag without a frame start");
    tx_flag_hold_a: assert property ($fell(txIrqFlag) |-> $past(clrTx))
        else $error("transmit flag dropped without clear");
    rx_flag_hold_a: assert property ($fell(rxIrqFlag) |-> $past(clrRx))
        else $error("receive flag dropped without clear");
    tx_quiet_a: assert property (!txSeen_r |-> !$rose(txIrqFlag))
        else $error("transmit flag with nothing sent");
    line_idle_a: assert property (!txSeen_r && !brkSeen_r |-> serialTxLine)
        else $error("transmit line left idle level");
endmodule
bind uart_tx_rx_interrupt_fifo uart_tx_rx_interrupt_fifo_checker i_checker (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serialRxLine(serialRxLine),
    .serialTxLine(serialTxLine), .txIrqFlag(txIrqFlag), .rxIrqFlag(rxIrqFlag));
`default_nettype wire

//--- verification/uart_tx_rx_interrupt_fifo_tb_top.sv
/*
 * Testbench: drives the serial port over AHB-Lite and through a far-side
 * peer. Assumes divisor 0 after reset, so one bit is 16 clocks.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_tx_rx_interrupt_fifo_tb_top;
    import uart_pkg::*;
    localparam int BIT = 16;
    localparam int FRAME = 10 * BIT;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout, hresp, serialRxLine, serialTxLine, txIrqFlag, rxIrqFlag;
    int errTotal = 0;
    int nCompared = 0;
    uart_tx_rx_interrupt_fifo i_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .serialRxLine(serialRxLine), .serialTxLine(serialTxLine),
        .txIrqFlag(txIrqFlag), .rxIrqFlag(rxIrqFlag));
    uart_peer #(.BIT(BIT)) i_peer (.clk(clk), .rxLine(serialRxLine), .txLine(serialTxLine));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic results();
        if (errTotal == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nCompared++;
        if (g !== e) begin
            errTotal++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic busRw(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic busWr(input logic [7:0] a, input logic [31:0] d);
        busRw(1'b1, a, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        busRw(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask
    // Parity mode and divisor register; stop sample lands half a bit after the peer returns
    task automatic parRx();
        busWr(BAUD_OFS, 32'h0000_0003);
        rdChk(BAUD_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
        busWr(BAUD_OFS, 32'h0000_0000);
        busWr(CTRL_OFS, 32'h0000_0003);
        rdChk(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0003);
        i_peer.send(8'h5A);
        repeat (2 * BIT) @(posedge clk);
        rdChk(STATUS_OFS, 32'h0000_000D, 32'h0000_0009);
        rdChk(RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_005A);
    endtask
    task automatic txIrq();
        rdChk(STATUS_OFS, 32'hFFFF_FFFF, 32'h0000_0200);
        rdChk(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
        busWr(CTRL_OFS, 32'h0000_0001);
        busWr(TXDATA_OFS, 32'h0000_00A5);
        repeat (FRAME + BIT) @(posedge clk);
        chk(txIrqFlag, 1'b1);
        chk(i_peer.got, 8'hA5);
        busWr(IFLAG_OFS, 32'h0000_0001);
        busWr(STATUS_OFS, 32'h0000_8000);
        for (int k = 1; k < 4; k++) begin
            busWr(TXDATA_OFS, k);
        end
        busWr(IFLAG_OFS, 32'h0000_0001);
        // Mid-frame checks keep clear of move timing
        repeat (FRAME + FRAME / 2) @(posedge clk);
        chk(txIrqFlag, 1'b0);
        repeat (FRAME) @(posedge clk);
        chk(txIrqFlag, 1'b1);
        repeat (FRAME) @(posedge clk);
    endtask
    task automatic brkTx();
        busWr(IFLAG_OFS, 32'h0000_0001);
        busWr(STATUS_OFS, 32'h0000_8800);
        repeat (8 * BIT) @(posedge clk);
        chk(serialTxLine, 1'b0);
        repeat (5 * BIT) @(posedge clk);
        busWr(STATUS_OFS, 32'h0000_8000);
        repeat (2 * BIT) @(posedge clk);
        chk(serialTxLine, 1'b1);
        chk(txIrqFlag, 1'b0);
    endtask
    task automatic rxThresh();
        logic exp;
        for (int s = 0; s < 4; s++) begin
            busWr(STATUS_OFS, s << RXSEL_LSB);
            busWr(IFLAG_OFS, 32'h0000_0002);
            for (int k = 1; k < 5; k++) begin
                i_peer.send(8'(16 * s + k));
                exp = (s < 2) || (s == 2 && k == 3) || (s == 3 && k == 4);
                chk(rxIrqFlag, exp);
                busWr(IFLAG_OFS, 32'h0000_0002);
            end
            if (s == 3) begin
                i_peer.send(8'hEE);
            end
            rdChk(STATUS_OFS, 32'h0000_0003, (s == 3) ? 32'h0000_0003 : 32'h0000_0001);
            for (int k = 1; k < 5; k++) begin
                rdChk(RXDATA_OFS, 32'hFFFF_FFFF, 16 * s + k);
            end
            rdChk(STATUS_OFS, 32'h0000_0003, (s == 3) ? 32'h0000_0002 : 32'h0000_0000);
            rdChk(RXDATA_OFS, 32'hFFFF_FFFF, 16 * s + 4);
        end
        busWr(STATUS_OFS, 32'h0000_0000);
        rdChk(STATUS_OFS, 32'h0000_0002, 32'h0000_0000);
    endtask
    task automatic midReset();
        i_peer.send(8'h5A);
        repeat (2 * BIT) @(posedge clk);
        rdChk(STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdChk(STATUS_OFS, 32'h0000_0001, 32'h0000_0000);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        txIrq();
        brkTx();
        rxThresh();
        parRx();
        midReset();
        results();
    end
    // Whole run needs well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        errTotal++;
        results();
    end
endmodule
`default_nettype wire
